// *** verilog/alarm_pkg.sv ***
// constants and types shared by the alarm evaluator files
`default_nettype none
package alarm_pkg;
	localparam int NUM_CHANNELS = 3;
	localparam int DATA_W = 16;
	localparam int WIDE_W = 18;
	localparam int TYPE_W = 5;
	localparam int DELAY_W = 10;
	localparam int CHAN_W = 2;
	typedef logic signed [WIDE_W-1:0] wide_t;
	typedef enum logic [2:0] {
		field_type,
		field_value,
		field_upper,
		field_lower,
		field_hysteresis,
		field_on_delay,
		field_off_delay
	} field_e;
	// alarm type codes
	localparam logic [TYPE_W-1:0] TYPE_OFF = 5'h00;
	localparam logic [TYPE_W-1:0] TYPE_OUTSIDE = 5'h01;
	localparam logic [TYPE_W-1:0] TYPE_DEV_UPPER = 5'h02;
	localparam logic [TYPE_W-1:0] TYPE_DEV_LOWER = 5'h03;
	localparam logic [TYPE_W-1:0] TYPE_INSIDE = 5'h04;
	localparam logic [TYPE_W-1:0] TYPE_OUTSIDE_STBY = 5'h05;
	localparam logic [TYPE_W-1:0] TYPE_DEV_UPPER_STBY = 5'h06;
	localparam logic [TYPE_W-1:0] TYPE_DEV_LOWER_STBY = 5'h07;
	localparam logic [TYPE_W-1:0] TYPE_ABS_UPPER = 5'h08;
	localparam logic [TYPE_W-1:0] TYPE_ABS_LOWER = 5'h09;
	localparam logic [TYPE_W-1:0] TYPE_ABS_UPPER_STBY = 5'h0A;
	localparam logic [TYPE_W-1:0] TYPE_ABS_LOWER_STBY = 5'h0B;
	localparam logic [TYPE_W-1:0] TYPE_LOOP_BREAK = 5'h0C;
	localparam logic [TYPE_W-1:0] TYPE_RATE = 5'h0D;
	localparam logic [TYPE_W-1:0] TYPE_SP_UPPER = 5'h0E;
	localparam logic [TYPE_W-1:0] TYPE_SP_LOWER = 5'h0F;
	localparam logic [TYPE_W-1:0] TYPE_MV_UPPER = 5'h10;
	localparam logic [TYPE_W-1:0] TYPE_MV_LOWER = 5'h11;
	localparam logic [TYPE_W-1:0] TYPE_RSP_UPPER = 5'h12;
	localparam logic [TYPE_W-1:0] TYPE_RSP_LOWER = 5'h13;
	localparam logic [TYPE_W-1:0] TYPE_RESET = TYPE_DEV_UPPER;
	localparam logic [CHAN_W-1:0] LOOP_BREAK_CHANNEL = 2'h0;
	// reset values of the stored settings and the delay limit
	localparam logic [DATA_W-1:0] VALUE_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] HYST_RESET = 16'h0002;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 10'h000;
	localparam logic [DELAY_W-1:0] DELAY_MAX_S = 10'h3E7;
	// timing
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int DELAY_UNIT_NS = 1000000000;
	localparam int TICK_CYCLES = DELAY_UNIT_NS / CLOCK_PERIOD_NS;
	localparam int TICK_W = 24;
endpackage : alarm_pkg
`default_nettype wire

// *** verilog/alarm_condition.sv ***
// combinational alarm condition with hysteresis for one channel
`default_nettype none
module alarm_condition
	import alarm_pkg::*;
(
	input wire logic [alarm_pkg::TYPE_W-1:0] alarm_type,
	input wire logic heat_cool_mode,
	input wire logic remote_sp_present,
	input wire logic signed [alarm_pkg::DATA_W-1:0] set_point,
	input wire logic signed [alarm_pkg::DATA_W-1:0] measured_value,
	input wire logic signed [alarm_pkg::DATA_W-1:0] manipulated_output,
	input wire logic signed [alarm_pkg::DATA_W-1:0] cooling_output,
	input wire logic signed [alarm_pkg::DATA_W-1:0] remote_setpoint,
	input wire logic signed [alarm_pkg::DATA_W-1:0] alarm_value,
	input wire logic signed [alarm_pkg::DATA_W-1:0] alarm_upper,
	input wire logic signed [alarm_pkg::DATA_W-1:0] alarm_lower,
	input wire logic signed [alarm_pkg::DATA_W-1:0] hysteresis,
	input wire logic state,
	output logic next_state
);
	function automatic wide_t widen(input logic signed [DATA_W-1:0] v);
		return wide_t'(v);
	endfunction : widen

	// once on, the alarm holds until the quantity backs off by the hysteresis
	function automatic logic upper_hit(input wide_t q, input wide_t x, input wide_t h,
			input logic st);
		return st ? (q > x - h) : (q > x);
	endfunction : upper_hit

	function automatic logic lower_hit(input wide_t q, input wide_t x, input wide_t h,
			input logic st);
		return st ? (q < x + h) : (q < x);
	endfunction : lower_hit

	wide_t sp;
	wide_t pv;
	wide_t x;
	wide_t hi;
	wide_t lo;
	wide_t h;
	logic outside;
	logic overlap;
	logic negative;

	assign sp = widen(set_point);
	assign pv = widen(measured_value);
	assign x = widen(alarm_value);
	assign hi = sp + widen(alarm_upper);
	assign lo = sp - widen(alarm_lower);
	assign h = widen(hysteresis);
	assign outside = upper_hit(pv, hi, h, state) | lower_hit(pv, lo, h, state);
	assign overlap = (hi - h) <= (lo + h);
	assign negative = alarm_value[DATA_W-1];

	always_comb begin
		case (alarm_type)
			TYPE_OUTSIDE: next_state = outside;
			TYPE_OUTSIDE_STBY: next_state = outside & ~overlap;
			TYPE_INSIDE: begin
				if (state) begin
					next_state = (pv > lo - h) && (pv < hi + h);
				end else begin
					next_state = (pv >= lo) && (pv <= hi);
				end
			end
			TYPE_DEV_UPPER, TYPE_DEV_UPPER_STBY: next_state = upper_hit(pv, sp + x, h, state);
			TYPE_DEV_LOWER, TYPE_DEV_LOWER_STBY: next_state = lower_hit(pv, sp - x, h, state);
			TYPE_ABS_UPPER, TYPE_ABS_UPPER_STBY: next_state = upper_hit(pv, x, h, state);
			TYPE_ABS_LOWER, TYPE_ABS_LOWER_STBY: next_state = lower_hit(pv, x, h, state);
			TYPE_SP_UPPER: next_state = upper_hit(sp, x, h, state);
			TYPE_SP_LOWER: next_state = lower_hit(sp, x, h, state);
			TYPE_MV_UPPER: begin
				if (heat_cool_mode) begin
					// heating side only
					next_state = negative | upper_hit(widen(manipulated_output), x, h, state);
				end else begin
					next_state = upper_hit(widen(manipulated_output), x, h, state);
				end
			end
			TYPE_MV_LOWER: begin
				if (heat_cool_mode) begin
					// cooling side only
					next_state = negative | lower_hit(widen(cooling_output), x, h, state);
				end else begin
					next_state = lower_hit(widen(manipulated_output), x, h, state);
				end
			end
			// evaluated in local and remote mode alike
			TYPE_RSP_UPPER: next_state = remote_sp_present &
				upper_hit(widen(remote_setpoint), x, h, state);
			TYPE_RSP_LOWER: next_state = remote_sp_present &
				lower_hit(widen(remote_setpoint), x, h, state);
			default: next_state = 1'b0;
		endcase
	end
endmodule : alarm_condition
`default_nettype wire

// *** verilog/alarm_delay.sv ***
// on and off delay filter for one alarm output
`default_nettype none
module alarm_delay
	import alarm_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic raw,
	input wire logic [alarm_pkg::DELAY_W-1:0] on_delay,
	input wire logic [alarm_pkg::DELAY_W-1:0] off_delay,
	output logic out
);
	logic [DELAY_W-1:0] count;
	logic [DELAY_W-1:0] delay;

	assign delay = raw ? on_delay : off_delay;

	// the first second is counted from the next tick, so a delay of n seconds
	// can fall short by up to one tick period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= DELAY_RESET;
			out <= 1'b0;
		end else if (raw == out) begin
			count <= DELAY_RESET;
		end else if (delay == DELAY_RESET) begin
			out <= raw;
		end else if (tick) begin
			if (count == delay - 10'h001) begin
				out <= raw;
				count <= DELAY_RESET;
			end else begin
				count <= count + 10'h001;
			end
		end
	end
endmodule : alarm_delay
`default_nettype wire

// *** verilog/alarm_type_evaluator.sv ***
// alarm type evaluator: settings store, per-channel conditions and delays
// Summary of operation
// - type 14 alarms when the set point is above the alarm value.
// - type 15 alarms when the set point is below the alarm value.
// - type 16 alarms when the manipulated output is above the alarm value.
// - type 17 alarms when the manipulated output is below the alarm value.
// - type 18 alarms when the remote set point is above the alarm value.
// - type 19 alarms when the remote set point is below the alarm value.
// - in heating/cooling, type 16 looks only at the heating output.
// - in heating/cooling, type 17 looks only at the cooling output.
// - types 1, 4 and 5 use separate upper and lower limits per channel.
// - type 5 stays off while the two hysteresis bands overlap.
// - remote set point types need a remote input, work in both modes.
// - loop break type is refused on position-proportional variants.
// - each channel has its own type, reset to 2; type 0 means off.
// - each output has on and off delays of 0 to 999 seconds.
`default_nettype none
module alarm_type_evaluator
	import alarm_pkg::*;
#(
	parameter int TICK_PERIOD = alarm_pkg::TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic heat_cool_mode,
	input wire logic position_proportional,
	input wire logic remote_sp_present,
	input wire logic signed [alarm_pkg::DATA_W-1:0] set_point,
	input wire logic signed [alarm_pkg::DATA_W-1:0] measured_value,
	input wire logic signed [alarm_pkg::DATA_W-1:0] manipulated_output,
	input wire logic signed [alarm_pkg::DATA_W-1:0] cooling_output,
	input wire logic signed [alarm_pkg::DATA_W-1:0] remote_setpoint,
	input wire logic cfg_write,
	input wire logic [alarm_pkg::CHAN_W-1:0] cfg_channel,
	input wire alarm_pkg::field_e cfg_field,
	input wire logic [alarm_pkg::DATA_W-1:0] cfg_data,
	output logic cfg_reject,
	output logic [alarm_pkg::NUM_CHANNELS-1:0] alarm_out,
	output logic [alarm_pkg::NUM_CHANNELS-1:0][alarm_pkg::TYPE_W-1:0] active_type
);
	logic [NUM_CHANNELS-1:0][DATA_W-1:0] value;
	logic [NUM_CHANNELS-1:0][DATA_W-1:0] upper;
	logic [NUM_CHANNELS-1:0][DATA_W-1:0] lower;
	logic [NUM_CHANNELS-1:0][DATA_W-1:0] hyst;
	logic [NUM_CHANNELS-1:0][DELAY_W-1:0] on_delay;
	logic [NUM_CHANNELS-1:0][DELAY_W-1:0] off_delay;
	logic [NUM_CHANNELS-1:0] state;
	logic [NUM_CHANNELS-1:0] next_state;
	logic [TICK_W-1:0] tick_count;
	logic tick;
	logic accept;

	// decides whether a type code may be stored on a given channel
	function automatic logic type_allowed(input logic [TYPE_W-1:0] code,
			input logic [CHAN_W-1:0] ch, input logic rsp, input logic pos);
		logic ok;
		ok = code <= TYPE_RSP_LOWER;
		if (code == TYPE_LOOP_BREAK) begin
			ok = (ch == LOOP_BREAK_CHANNEL) && !pos;
		end
		if (code == TYPE_RSP_UPPER || code == TYPE_RSP_LOWER) begin
			ok = rsp;
		end
		return ok;
	endfunction : type_allowed

	function automatic logic field_allowed(input field_e f, input logic [DATA_W-1:0] d,
			input logic [CHAN_W-1:0] ch, input logic rsp, input logic pos);
		logic ok;
		case (f)
			field_type: ok = (d[DATA_W-1:TYPE_W] == '0) &&
				type_allowed(d[TYPE_W-1:0], ch, rsp, pos);
			field_hysteresis: ok = !d[DATA_W-1] && (d != VALUE_RESET);
			field_on_delay, field_off_delay: ok = (d[DATA_W-1:DELAY_W] == '0) &&
				(d[DELAY_W-1:0] <= DELAY_MAX_S);
			field_value, field_upper, field_lower: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : field_allowed

	assign accept = cfg_write && (int'(cfg_channel) < NUM_CHANNELS) &&
		field_allowed(cfg_field, cfg_data, cfg_channel, remote_sp_present,
		position_proportional);

	// one pulse per second drives all delay counters
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else if (tick_count == TICK_W'(TICK_PERIOD - 1)) begin
			tick_count <= '0;
			tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 24'h000001;
			tick <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_reject <= 1'b0;
		end else begin
			cfg_reject <= cfg_write && !accept;
		end
	end

	// type codes: each channel keeps its own, upper deviation after reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				active_type[i] <= TYPE_RESET;
			end
		end else if (accept && cfg_field == field_type) begin
			active_type[cfg_channel] <= cfg_data[TYPE_W-1:0];
		end
	end

	// alarm value and the independent upper and lower limits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				value[i] <= VALUE_RESET;
				upper[i] <= VALUE_RESET;
				lower[i] <= VALUE_RESET;
			end
		end else if (accept) begin
			case (cfg_field)
				field_value: value[cfg_channel] <= cfg_data;
				field_upper: upper[cfg_channel] <= cfg_data;
				field_lower: lower[cfg_channel] <= cfg_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				hyst[i] <= HYST_RESET;
			end
		end else if (accept && cfg_field == field_hysteresis) begin
			hyst[cfg_channel] <= cfg_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				on_delay[i] <= DELAY_RESET;
				off_delay[i] <= DELAY_RESET;
			end
		end else if (accept && cfg_field == field_on_delay) begin
			on_delay[cfg_channel] <= cfg_data[DELAY_W-1:0];
		end else if (accept && cfg_field == field_off_delay) begin
			off_delay[cfg_channel] <= cfg_data[DELAY_W-1:0];
		end
	end

	// undelayed alarm state; a type change restarts from off to avoid
	// carrying a latched state from the old comparison
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				if (accept && cfg_field == field_type && int'(cfg_channel) == i) begin
					state[i] <= 1'b0;
				end else begin
					state[i] <= next_state[i];
				end
			end
		end
	end

	for (genvar g = 0; g < NUM_CHANNELS; g++) begin : gen_channel
		alarm_condition u_condition (
			.alarm_type(active_type[g]),
			.heat_cool_mode(heat_cool_mode),
			.remote_sp_present(remote_sp_present),
			.set_point(set_point),
			.measured_value(measured_value),
			.manipulated_output(manipulated_output),
			.cooling_output(cooling_output),
			.remote_setpoint(remote_setpoint),
			.alarm_value(value[g]),
			.alarm_upper(upper[g]),
			.alarm_lower(lower[g]),
			.hysteresis(hyst[g]),
			.state(state[g]),
			.next_state(next_state[g])
		);

		alarm_delay u_delay (
			.clk(clk),
			.reset(reset),
			.tick(tick),
			.raw(state[g]),
			.on_delay(on_delay[g]),
			.off_delay(off_delay[g]),
			.out(alarm_out[g])
		);
	end
endmodule : alarm_type_evaluator
`default_nettype wire

// *** testbench/alarm_type_evaluator_properties.sv ***
// port assertions for the alarm type evaluator
`default_nettype none
module alarm_type_evaluator_properties
	import alarm_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic position_proportional,
	input wire logic remote_sp_present,
	input wire logic cfg_write,
	input wire logic [alarm_pkg::CHAN_W-1:0] cfg_channel,
	input wire alarm_pkg::field_e cfg_field,
	input wire logic [alarm_pkg::DATA_W-1:0] cfg_data,
	input wire logic cfg_reject,
	input wire logic [alarm_pkg::NUM_CHANNELS-1:0] alarm_out,
	input wire logic [alarm_pkg::NUM_CHANNELS-1:0][alarm_pkg::TYPE_W-1:0] active_type
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence type_write_s;
		cfg_write && cfg_field == field_type && cfg_channel != 2'h3;
	endsequence
	// every refusal cause excluded, so only a legal code reaches the store
	sequence type_ok_s;
		cfg_data <= 16'h0013
		&& !(cfg_data == 16'h000C && (cfg_channel != 2'h0 || position_proportional))
		&& !(cfg_data[15:1] == 15'h0009 && !remote_sp_present);
	endsequence
	reset_values_a: assert property ($fell(reset) |-> alarm_out == 3'h0 && !cfg_reject
		&& active_type == {NUM_CHANNELS{TYPE_RESET}}) else $error("bad reset state");
	type_store_a: assert property (type_write_s ##0 type_ok_s |=> !cfg_reject
		&& active_type[$past(cfg_channel)] == $past(cfg_data[4:0])) else $error("type not stored");
	type_range_a: assert property (type_write_s ##0 cfg_data > 16'h0013 |=> cfg_reject)
		else $error("unknown type taken");
	bad_channel_a: assert property (cfg_write && cfg_channel == 2'h3
		|=> cfg_reject && $stable(active_type)) else $error("channel 3 taken");
	loop_break_a: assert property (type_write_s ##0 cfg_data == 16'h000C
		&& position_proportional |=> cfg_reject) else $error("loop break type taken");
	remote_absent_a: assert property (type_write_s ##0 cfg_data[15:1] == 15'h0009
		&& !remote_sp_present |=> cfg_reject) else $error("remote type taken");
	delay_range_a: assert property (cfg_write && cfg_channel != 2'h3 && cfg_data > 16'h03E7
		&& (cfg_field == field_on_delay || cfg_field == field_off_delay) |=> cfg_reject)
		else $error("delay over range taken");
	reject_cause_a: assert property (cfg_reject |-> $past(cfg_write) && $stable(active_type))
		else $error("stray reject");
	type_hold_a: assert property (!$stable(active_type) |-> $past(cfg_write))
		else $error("type changed without write");
endmodule : alarm_type_evaluator_properties
bind alarm_type_evaluator alarm_type_evaluator_properties u_props (.clk, .reset,
	.position_proportional, .remote_sp_present, .cfg_write, .cfg_channel, .cfg_field,
	.cfg_data, .cfg_reject, .alarm_out, .active_type);
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the alarm type evaluator
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import alarm_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hc = 1'b0;
	logic pos = 1'b0;
	logic rsp = 1'b1;
	logic signed [15:0] sp = 16'h0064, pv = 16'h0064, mv = 16'h0064;
	logic signed [15:0] cool = 16'h0064, rsv = 16'h0064;
	logic cfg_write = 1'b0;
	logic [1:0] cfg_channel = 2'h0;
	field_e cfg_field = field_type;
	logic [15:0] cfg_data = 16'h0000;
	logic cfg_reject, rej;
	logic [2:0] alarm_out;
	logic [2:0][4:0] active_type;
	int fails = 0, compares = 0, cycles = 0;
	// one row per type case: code, driven quantity, heat/cool, output at 110 and at 90
	localparam logic [4:0] AC [13] = '{5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h10,
		5'h11, 5'h00, 5'h0D, 5'h09, 5'h0A, 5'h0B};
	localparam int AS [13] = '{0, 0, 1, 1, 3, 3, 1, 2, 0, 0, 4, 4, 4};
	localparam logic AH [13] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0};
	localparam logic HI [13] = '{1, 0, 1, 0, 1, 0, 1, 0, 0, 0, 0, 1, 0};
	localparam logic LO [13] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 0, 1, 0, 1};
	// refused writes, all with position_proportional high and no remote input
	localparam logic [1:0] RC [7] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1};
	localparam field_e RF [7] = '{field_type, field_type, field_type, field_type,
		field_type, field_on_delay, field_hysteresis};
	localparam logic [15:0] RD [7] = '{16'h0002, 16'h0014, 16'h000C, 16'h000C, 16'h0012,
		16'h03E8, 16'h0000};
	alarm_type_evaluator #(.TICK_PERIOD(10)) u_alarm_type_evaluator (.clk(clk),
		.reset(reset), .heat_cool_mode(hc), .position_proportional(pos),
		.remote_sp_present(rsp), .set_point(sp), .measured_value(pv),
		.manipulated_output(mv), .cooling_output(cool), .remote_setpoint(rsv),
		.cfg_write(cfg_write), .cfg_channel(cfg_channel), .cfg_field(cfg_field),
		.cfg_data(cfg_data), .cfg_reject(cfg_reject), .alarm_out(alarm_out),
		.active_type(active_type));
	always #50 clk = ~clk;
	// the ceiling leaves about twice the cycles the scenarios need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 600) begin
			fails++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic check_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t output %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_type(input logic [4:0] got, input logic [4:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t type %0d expected %0d", $time, got, exp);
		end
	endtask : check_type
	task automatic cfg(input logic [1:0] ch, input field_e f, input logic [15:0] d);
		@(negedge clk);
		cfg_write = 1'b1;
		cfg_channel = ch;
		cfg_field = f;
		cfg_data = d;
		@(negedge clk);
		cfg_write = 1'b0;
		rej = cfg_reject;
	endtask : cfg
	// the chosen quantity gets v, every other sits at 100 (16'h0064)
	task automatic drive(input int sel, input logic signed [15:0] v, input int n);
		sp = (sel == 0) ? v : 16'h0064;
		mv = (sel == 1) ? v : 16'h0064;
		cool = (sel == 2) ? v : 16'h0064;
		rsv = (sel == 3) ? v : 16'h0064;
		pv = (sel == 4) ? v : 16'h0064;
		repeat (n) @(negedge clk);
	endtask : drive
	task automatic t_reset();
		for (int c = 0; c < 3; c++)
			check_type(active_type[c], TYPE_RESET);
		check_bit(alarm_out[0], 1'b0);
	endtask : t_reset
	task automatic t_types();
		for (int i = 0; i < 13; i++) begin
			hc = AH[i];
			drive(4, 16'h0064, 1);
			cfg(2'h1, field_value, 16'h0064);
			cfg(2'h1, field_type, {11'h000, AC[i]});
			drive(AS[i], 16'h006E, 3);
			check_bit(alarm_out[1], HI[i]);
			drive(AS[i], 16'h005A, 3);
			check_bit(alarm_out[1], LO[i]);
		end
	endtask : t_types
	task automatic t_hc_negative();
		hc = 1'b1;
		drive(4, 16'h0064, 1);
		cfg(2'h1, field_value, 16'hFFFB);
		cfg(2'h1, field_type, 16'h0010);
		// heating output below the alarm value, so only the negative value can raise it
		drive(1, 16'hFFF0, 3);
		check_bit(alarm_out[1], 1'b1);
		cfg(2'h1, field_type, 16'h0011);
		drive(1, 16'hFFF0, 3);
		check_bit(alarm_out[1], 1'b1);
		hc = 1'b0;
	endtask : t_hc_negative
	task automatic t_limits();
		cfg(2'h2, field_upper, 16'h0032);
		cfg(2'h2, field_lower, 16'h001E);
		cfg(2'h2, field_type, 16'h0001);
		drive(4, 16'h00A0, 3);
		check_bit(alarm_out[2], 1'b1);
		drive(4, 16'h0064, 3);
		check_bit(alarm_out[2], 1'b0);
		drive(4, 16'h003C, 3);
		check_bit(alarm_out[2], 1'b1);
		cfg(2'h2, field_type, 16'h0004);
		drive(4, 16'h0064, 3);
		check_bit(alarm_out[2], 1'b1);
		drive(4, 16'h00A0, 3);
		check_bit(alarm_out[2], 1'b0);
		cfg(2'h2, field_upper, 16'h0001);
		cfg(2'h2, field_lower, 16'h0001);
		cfg(2'h2, field_type, 16'h0005);
		drive(4, 16'h00A0, 3);
		check_bit(alarm_out[2], 1'b0);
	endtask : t_limits
	task automatic t_refuse();
		pos = 1'b1;
		rsp = 1'b0;
		for (int i = 0; i < 7; i++) begin
			cfg(RC[i], RF[i], RD[i]);
			check_bit(rej, 1'b1);
			check_type(active_type[0], 5'h11);
			check_type(active_type[1], 5'h11);
		end
		pos = 1'b0;
		rsp = 1'b1;
		cfg(2'h0, field_type, 16'h000C);
		check_bit(rej, 1'b0);
		check_type(active_type[0], 5'h0C);
	endtask : t_refuse
	task automatic t_delay();
		// start from a quiet channel so the zero delays cannot pass an early alarm
		cfg(2'h1, field_value, 16'h0064);
		drive(4, 16'h0064, 1);
		cfg(2'h1, field_type, 16'h0008);
		cfg(2'h1, field_on_delay, 16'h03E7);
		check_bit(rej, 1'b0);
		cfg(2'h1, field_on_delay, 16'h0003);
		cfg(2'h1, field_off_delay, 16'h0002);
		drive(4, 16'h006E, 20);
		check_bit(alarm_out[1], 1'b0);
		drive(4, 16'h006E, 13);
		check_bit(alarm_out[1], 1'b1);
		drive(4, 16'h005A, 10);
		check_bit(alarm_out[1], 1'b1);
		drive(4, 16'h005A, 13);
		check_bit(alarm_out[1], 1'b0);
	endtask : t_delay
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		t_reset();
		cfg(2'h0, field_type, 16'h0011);
		t_types();
		t_hc_negative();
		t_limits();
		t_refuse();
		t_delay();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
